//--- logic/adc_pd_pkg.sv
// Purpose: constants and types of the power control
// Assumes: pclk at 50 MHz
// Notes:   times in ns
package adc_pd_pkg;

    // =========================================================
    // clock and timing
    localparam int SYS_CLK_HZ     = 50_000_000;
    localparam int SYS_CLK_MHZ    = 50;
    localparam int T_POR_NS       = 10_000;
    localparam int T_FAST_NS      = 5_000;
    localparam int T_FULL_NS      = 300_000;
    localparam int T_EXTCOMP_NS   = 20_000_000;
    localparam int T_REFOFF_NS    = 2_000;
    localparam int POR_CYCLES     = T_POR_NS * SYS_CLK_MHZ / 1000;
    localparam int FAST_CYCLES    = T_FAST_NS * SYS_CLK_MHZ / 1000;
    localparam int FULL_CYCLES    = T_FULL_NS * SYS_CLK_MHZ / 1000;
    localparam int EXTCOMP_CYCLES = T_EXTCOMP_NS * SYS_CLK_MHZ / 1000;
    localparam int REFOFF_CYCLES  = T_REFOFF_NS * SYS_CLK_MHZ / 1000;

    // =========================================================
    // internal conversion clock
    localparam int CONV_HZ_FLOAT = 1_800_000;
    localparam int CONV_HZ_HIGH  = 225_000;
    localparam int DIV_FLOAT     = SYS_CLK_HZ / CONV_HZ_FLOAT;
    localparam int DIV_HIGH      = SYS_CLK_HZ / CONV_HZ_HIGH;
    localparam int CONV_STEPS    = 13;

    // =========================================================
    // widths and types
    localparam int TIMER_W  = 20;
    localparam int DIV_W    = 8;
    localparam int RESULT_W = 12;
    typedef logic [TIMER_W-1:0]  tcount_t;
    typedef logic [DIV_W-1:0]    div_t;
    typedef logic [RESULT_W-1:0] result_t;
    typedef logic [3:0]          bitcnt_t;

    // =========================================================
    // shutdown pin codes
    localparam logic [1:0] PIN_LOW   = 2'h0;
    localparam logic [1:0] PIN_FLOAT = 2'h1;
    localparam logic [1:0] PIN_HIGH  = 2'h2;

    // =========================================================
    // register map and reset values
    localparam logic [11:0] OFS_CONFIG = 12'h000;
    localparam logic [11:0] OFS_SAMPLE = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;
    localparam logic [11:0] OFS_CTRL   = 12'h00c;
    localparam logic        CONFIG_RST = 1'b0;
    localparam result_t     SAMPLE_RST = 12'h000;
    localparam logic        STROBE_RST = 1'b1;
    localparam bitcnt_t     BYTE_LAST  = 4'h7;
    localparam bitcnt_t     BIT5_OUT   = 4'h7;

    typedef enum logic [2:0] {
        ST_POR   = 3'h0,
        ST_READY = 3'h1,
        ST_CONV  = 3'h3,
        ST_DOWN  = 3'h2,
        ST_WAKE  = 3'h6,
        ST_HWPD  = 3'h7
    } pd_state_e;

endpackage : adc_pd_pkg

//--- logic/power_timer_if.sv
// Purpose: sequencer to timer carrier
// Assumes: one clock domain
// Notes:   load is a one-cycle pulse, expired is a level
`timescale 1ns/100ps
interface power_timer_if;
    logic                     load;
    adc_pd_pkg::tcount_t      cycles;
    logic                     expired;
    modport timer (input load, input cycles, output expired);
    modport user  (output load, output cycles, input expired);
endinterface : power_timer_if

//--- logic/pin_sync.sv
// Purpose: two-flop synchroniser for asynchronous pins
// Assumes: inputs unrelated to pclk
// Notes:   only the second stage leaves this module
`timescale 1ns/100ps
module pin_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // pins
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    if (W < 1) begin : g_bad_width
        $error("width below one");
    end

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } sync_s;

    sync_s r;
    sync_s next_r;

    always_comb begin
        next_r      = r;
        next_r.meta = d;
        next_r.sync = r.meta;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign q = r.sync;
endmodule : pin_sync

//--- logic/power_timer.sv
// Purpose: down counter for power-on and power-up delays
// Assumes: counts pclk cycles
// Notes:   reset loads the power-on delay
`timescale 1ns/100ps
module power_timer (
    // clock and reset
    input  wire logic  pclk,
    input  wire logic  presetn,
    // request and status
    power_timer_if.timer tif
);
    typedef struct packed {
        adc_pd_pkg::tcount_t count;
    } timer_s;

    timer_s r;
    timer_s next_r;

    always_comb begin
        next_r = r;
        if (tif.load) begin
            next_r.count = tif.cycles;
        end else if (r.count != '0) begin
            next_r.count = r.count - 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r.count <= adc_pd_pkg::tcount_t'(adc_pd_pkg::POR_CYCLES);
        end else begin
            r <= next_r;
        end
    end

    assign tif.expired = (r.count == '0);
endmodule : power_timer

//--- logic/adc_power_down_control.sv
// Purpose: power sequencing of a serial converter
// Assumes: serial pins asynchronous to pclk
// Notes:   sample register stands in for the result
`timescale 1ns/100ps

// What this block does
// RULE1: power-on gives internal mode, strobe high
// RULE2: host waits out reset interval
// RULE3: first one is the start bit
// RULE4: zeros out before first conversion
// RULE5: host keeps serial clock above floor
// RULE6: host caps serial clock rate
// RULE7: low bits pick software power-down
// RULE8: pin low overrides all
// RULE9: conversion finishes before power-down
// RULE10: readout works in power-down
// RULE11: start bit wakes device
// RULE12: high bit stays up, else one conversion
// RULE13: host allows wake delays
// RULE14: host allows settle, dummy conversion
// RULE15: pin low aborts conversion
// RULE16: conversion clock follows pin
// RULE17: short wake with buffer off
// RULE18: fast keeps bandgap, full all off
// RULE19: power bits decode four modes
// RULE20: conversion starts on fall after byte
// RULE21: pin is two-bit three-level code
// RULE22: timer delays wake, then strobe released
module adc_power_down_control #(
    parameter int FULL_CYCLES    = adc_pd_pkg::FULL_CYCLES,
    parameter int EXTCOMP_CYCLES = adc_pd_pkg::EXTCOMP_CYCLES
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // serial link pins
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        din,
    input  wire logic [1:0]  shutdown_select_pin,
    output logic             dout,
    output logic             dout_oe,
    output logic             conversion_strobe,
    output logic             conversion_strobe_oe,
    // analog power enables
    output logic             analog_power_on,
    output logic             bandgap_on
);
    if (FULL_CYCLES < 1 || FULL_CYCLES >= (1 << adc_pd_pkg::TIMER_W) ||
        EXTCOMP_CYCLES < 1 ||
        EXTCOMP_CYCLES >= (1 << adc_pd_pkg::TIMER_W)) begin : g_bad_count
        $error("counts overflow timer");
    end

    // =========================================================
    // state
    typedef struct packed {
        adc_pd_pkg::pd_state_e state;
        logic                  sclk_d;
        adc_pd_pkg::bitcnt_t   rx_cnt;
        logic [7:0]            rx_sh;
        logic [7:0]            ctrl_byte;
        logic                  conv_pend;
        logic                  clk_mode;
        logic                  pd_after;
        logic                  pd_fast;
        adc_pd_pkg::bitcnt_t   step_cnt;
        adc_pd_pkg::div_t      div_cnt;
        adc_pd_pkg::result_t   out_sh;
        adc_pd_pkg::bitcnt_t   out_cnt;
        logic                  dout;
        logic                  strobe;
        logic                  first_done;
        logic                  t_load;
        adc_pd_pkg::tcount_t   t_cycles;
        logic                  ref_off;
        adc_pd_pkg::result_t   sample;
        logic [31:0]           prdata;
        logic                  slverr;
    } ctl_s;

    ctl_s r;
    ctl_s next_r;

    logic [4:0] pins_q;
    logic       s_sclk;
    logic       s_cs_n;
    logic       s_din;
    logic [1:0] s_pin;
    logic       rise;
    logic       fall;
    logic       hw_pd;

    power_timer_if tif ();

    pin_sync #(.W(5)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({~shutdown_select_pin, din, ~cs_n, sclk}),
        .q       (pins_q)
    );

    power_timer u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .tif     (tif)
    );

    assign s_sclk     = pins_q[0];
    // inverted through the flops so reset reads deselected, pin code 3, not low
    assign s_cs_n     = ~pins_q[1];
    assign s_din      = pins_q[2];
    assign s_pin      = ~pins_q[4:3]; // RULE21
    assign hw_pd      = (s_pin == adc_pd_pkg::PIN_LOW);
    assign rise       = s_sclk & ~r.sclk_d;
    assign fall       = ~s_sclk & r.sclk_d;
    assign tif.load   = r.t_load;
    assign tif.cycles = r.t_cycles;

    // =========================================================
    // helpers
    function automatic logic reg_hit(input logic [11:0] a);
        reg_hit = (a == adc_pd_pkg::OFS_CONFIG) ||
                  (a == adc_pd_pkg::OFS_SAMPLE) ||
                  (a == adc_pd_pkg::OFS_STATUS) ||
                  (a == adc_pd_pkg::OFS_CTRL);
    endfunction : reg_hit

    function automatic adc_pd_pkg::tcount_t wake_cycles(
        input logic       fast,
        input logic [1:0] pin,
        input logic       ref_off
    );
        if (ref_off) begin
            wake_cycles = adc_pd_pkg::tcount_t'(adc_pd_pkg::REFOFF_CYCLES);
        end else if (fast) begin
            wake_cycles = adc_pd_pkg::tcount_t'(adc_pd_pkg::FAST_CYCLES);
        end else if (pin == adc_pd_pkg::PIN_FLOAT) begin
            wake_cycles = adc_pd_pkg::tcount_t'(EXTCOMP_CYCLES);
        end else begin
            wake_cycles = adc_pd_pkg::tcount_t'(FULL_CYCLES);
        end
    endfunction : wake_cycles

    function automatic ctl_s finish(input ctl_s s);
        ctl_s f;
        f            = s;
        f.first_done = 1'b1;
        f.strobe     = 1'b1;
        f.state      = s.pd_after ? adc_pd_pkg::ST_DOWN // RULE9
                                  : adc_pd_pkg::ST_READY;
        finish       = f;
    endfunction : finish

    // =========================================================
    // next state
    always_comb begin
        logic [7:0]          byte_in;
        logic                mode;
        adc_pd_pkg::div_t    div_top;
        byte_in        = 8'h00;
        mode           = r.clk_mode;
        div_top        = 8'h00;
        next_r         = r;
        next_r.sclk_d  = s_sclk;
        next_r.t_load  = 1'b0;

        // apb: read data captured in setup
        if (psel && !penable) begin
            next_r.slverr = !reg_hit(paddr);
            case (paddr)
                adc_pd_pkg::OFS_CONFIG: next_r.prdata = {31'h0, r.ref_off};
                adc_pd_pkg::OFS_SAMPLE: next_r.prdata = {20'h0, r.sample};
                adc_pd_pkg::OFS_STATUS: next_r.prdata = {22'h0, r.pd_after,
                    s_pin, tif.expired, r.first_done, r.pd_fast,
                    r.clk_mode, r.state};
                adc_pd_pkg::OFS_CTRL:   next_r.prdata = {24'h0, r.ctrl_byte};
                default:                next_r.prdata = 32'h0;
            endcase
        end
        if (psel && penable && pwrite) begin
            if (paddr == adc_pd_pkg::OFS_CONFIG) begin
                next_r.ref_off = pwdata[0];
            end
            if (paddr == adc_pd_pkg::OFS_SAMPLE) begin
                next_r.sample = pwdata[11:0];
            end
        end

        // internal conversion clock divider
        if (s_pin == adc_pd_pkg::PIN_FLOAT) begin
            div_top = adc_pd_pkg::div_t'(adc_pd_pkg::DIV_FLOAT - 1); // RULE16
        end else begin
            div_top = adc_pd_pkg::div_t'(adc_pd_pkg::DIV_HIGH - 1); // RULE16
        end

        // serial receive
        if (s_cs_n) begin
            next_r.rx_cnt = '0;
        end else if (rise) begin
            if (r.rx_cnt == '0) begin
                if (s_din && !r.conv_pend &&
                    (r.state != adc_pd_pkg::ST_CONV || !r.clk_mode ||
                     r.out_cnt <= adc_pd_pkg::BIT5_OUT)) begin
                    next_r.rx_cnt = 4'h1; // RULE3
                    next_r.rx_sh  = 8'h01;
                    if (r.state == adc_pd_pkg::ST_DOWN) begin
                        next_r.state    = adc_pd_pkg::ST_WAKE; // RULE11
                        next_r.t_load   = 1'b1;
                        next_r.t_cycles = wake_cycles(r.pd_fast, s_pin,
                                                      r.ref_off);
                    end
                end
            end else if (r.rx_cnt == adc_pd_pkg::BYTE_LAST) begin
                next_r.ctrl_byte = {r.rx_sh[6:0], s_din};
                next_r.conv_pend = 1'b1;
                next_r.rx_cnt    = '0;
            end else begin
                next_r.rx_sh  = {r.rx_sh[6:0], s_din};
                next_r.rx_cnt = r.rx_cnt + 1'b1;
            end
        end

        // serial transmit on falling edges
        if (fall && !s_cs_n) begin
            if (r.out_cnt != '0) begin
                next_r.dout    = r.out_sh[11];
                next_r.out_sh  = {r.out_sh[10:0], 1'b0};
                next_r.out_cnt = r.out_cnt - 1'b1;
                if (r.state == adc_pd_pkg::ST_CONV && r.clk_mode &&
                    r.out_cnt == 4'h1) begin
                    next_r = finish(next_r);
                    next_r.strobe = 1'b0;
                end
            end else begin
                next_r.dout = 1'b0; // RULE4
            end
            if (r.state == adc_pd_pkg::ST_CONV && r.clk_mode) begin
                next_r.strobe = 1'b0;
            end
        end

        // control byte acts on the next fall
        if (fall && r.conv_pend) begin
            next_r.conv_pend = 1'b0;
            byte_in          = r.ctrl_byte;
            if (byte_in[1]) begin
                mode            = byte_in[0]; // RULE19
                next_r.clk_mode = byte_in[0];
                next_r.pd_after = 1'b0; // RULE12
            end else begin
                next_r.pd_after = 1'b1; // RULE7 RULE12
                next_r.pd_fast  = byte_in[0]; // RULE19
            end
            if (r.state == adc_pd_pkg::ST_READY ||
                r.state == adc_pd_pkg::ST_CONV) begin
                next_r.state    = adc_pd_pkg::ST_CONV; // RULE20
                next_r.step_cnt = '0;
                next_r.div_cnt  = '0;
                next_r.dout     = 1'b0;
                if (mode) begin
                    next_r.strobe  = 1'b1;
                    next_r.out_sh  = r.sample;
                    next_r.out_cnt = 4'hc;
                end else begin
                    next_r.strobe  = 1'b0;
                    next_r.out_cnt = '0;
                end
            end
        end

        // power sequencing
        case (r.state)
            adc_pd_pkg::ST_POR: begin
                if (tif.expired) begin
                    next_r.state = adc_pd_pkg::ST_READY; // RULE1
                end
            end
            adc_pd_pkg::ST_HWPD: begin
                next_r.state    = adc_pd_pkg::ST_WAKE;
                next_r.t_load   = 1'b1;
                next_r.t_cycles = wake_cycles(1'b0, s_pin, r.ref_off); // RULE17
            end
            adc_pd_pkg::ST_WAKE: begin
                if (tif.expired && !r.t_load) begin
                    next_r.state  = adc_pd_pkg::ST_READY; // RULE22
                    next_r.strobe = 1'b1; // RULE22
                end
            end
            adc_pd_pkg::ST_CONV: begin
                if (!r.clk_mode && next_r.state == adc_pd_pkg::ST_CONV) begin
                    if (r.div_cnt >= div_top) begin
                        next_r.div_cnt = '0;
                        if (r.step_cnt ==
                            adc_pd_pkg::bitcnt_t'(adc_pd_pkg::CONV_STEPS - 1))
                        begin
                            next_r         = finish(next_r);
                            next_r.out_sh  = r.sample;
                            next_r.out_cnt = 4'hc; // RULE10
                        end else begin
                            next_r.step_cnt = r.step_cnt + 1'b1;
                        end
                    end else begin
                        next_r.div_cnt = r.div_cnt + 1'b1;
                    end
                end
            end
            default: begin
            end
        endcase

        // pin low wins
        if (hw_pd) begin
            next_r.state     = adc_pd_pkg::ST_HWPD; // RULE8 RULE15
            next_r.conv_pend = 1'b0;
            next_r.rx_cnt    = '0;
            next_r.out_cnt   = '0;
            next_r.dout      = 1'b0;
            next_r.t_load    = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r          <= '0;
            r.state    <= adc_pd_pkg::ST_POR; // RULE1
            r.strobe   <= adc_pd_pkg::STROBE_RST; // RULE1
            r.ref_off  <= adc_pd_pkg::CONFIG_RST;
            r.sample   <= adc_pd_pkg::SAMPLE_RST;
        end else begin
            r <= next_r;
        end
    end

    // =========================================================
    // outputs
    assign prdata  = r.prdata;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & r.slverr;
    assign dout    = r.dout;
    assign dout_oe = ~s_cs_n & ~hw_pd;
    assign conversion_strobe    = r.strobe;
    assign conversion_strobe_oe = ~hw_pd & (~r.clk_mode | ~s_cs_n);
    assign analog_power_on = (r.state == adc_pd_pkg::ST_POR)   ||
                             (r.state == adc_pd_pkg::ST_READY) ||
                             (r.state == adc_pd_pkg::ST_CONV)  ||
                             (r.state == adc_pd_pkg::ST_WAKE);
    assign bandgap_on = analog_power_on | // RULE18
                        ((r.state == adc_pd_pkg::ST_DOWN) & r.pd_fast);
endmodule : adc_power_down_control

//--- test/adc_power_down_control_properties.sv
// Purpose: port properties of the sequencer
// Assumes: pins settle within a few pclk
// Notes:   bound to every instance of the block
`timescale 1ns/100ps
module adc_power_down_control_properties (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // pins
    input wire logic        cs_n,
    input wire logic [1:0]  shutdown_select_pin,
    input wire logic        dout_oe,
    input wire logic        conversion_strobe,
    input wire logic        conversion_strobe_oe,
    input wire logic        analog_power_on,
    input wire logic        bandgap_on
);
    logic [9:0] up_cnt;
    wire logic  pin_low = shutdown_select_pin == adc_pd_pkg::PIN_LOW;

    // =========================================================
    // cycles since reset, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_cnt <= 10'h000;
        end else if (up_cnt != 10'h3ff) begin
            up_cnt <= up_cnt + 10'h001;
        end
    end

    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);

    // =========================================================
    // assertions
    a_ready_const: assert property (pready)
        else $error("pready dropped");
    a_err_access: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access phase");
    a_rdata_hold: assert property (!$past(psel) |-> $stable(prdata))
        else $error("prdata moved without setup");
    a_por_ready:
        assert property (up_cnt > 10'h004 && up_cnt < 10'h1e0
            |-> conversion_strobe && conversion_strobe_oe && analog_power_on)
        else $error("power-on state lost");
    a_hw_off:
        assert property (pin_low [*5] |-> !analog_power_on && !bandgap_on)
        else $error("power on with pin low");
    a_hw_abort:
        assert property (pin_low [*5] |-> !dout_oe && !conversion_strobe_oe)
        else $error("outputs driven with pin low");
    a_gap_kept:
        assert property (analog_power_on |-> bandgap_on)
        else $error("bandgap off while powered");
    a_cs_release:
        assert property (cs_n [*4] |-> !dout_oe)
        else $error("dout driven while deselected");
    c_fast_pd: cover property (bandgap_on && !analog_power_on);
    c_full_pd: cover property (!bandgap_on && !pin_low);
    c_conv: cover property ($fell(conversion_strobe));
endmodule : adc_power_down_control_properties

bind adc_power_down_control adc_power_down_control_properties u_props (.*);

//--- test/serial_host_model.sv
// Purpose: host serial master on the converter link
// Assumes: mode 0 framing, 8 pclk per bit
// Notes:   clock rests low outside frames
`timescale 1ns/100ps
module serial_host_model (
    // clock
    input wire logic pclk,
    // link pins
    output logic     sclk,
    output logic     cs_n,
    output logic     din,
    input wire logic dout
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din  = 1'b0;
    end
    // deselected input shows the inverse of its last level
    task automatic select(input logic on);
        @(posedge pclk);
        cs_n <= !on;
        if (!on) begin
            din <= !din;
        end
    endtask : select
    // 160 ns bit; dout taken before each fall
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            @(posedge pclk);
            din <= tx[i];
            repeat (3) @(posedge pclk);
            sclk <= 1'b1;
            repeat (4) @(posedge pclk);
            rx[i] = dout;
            sclk <= 1'b0;
        end
    endtask : xfer
endmodule : serial_host_model

//--- test/adc_power_down_control_tb.sv
// Purpose: bench for the sequencer
// Assumes: host model drives the link
// Notes:   full and extcomp wake counts shortened
`timescale 1ns/100ps
module adc_power_down_control_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        sclk, cs_n, din, dout, dout_oe, err;
    logic        conversion_strobe, conversion_strobe_oe;
    logic        analog_power_on, bandgap_on;
    logic [1:0]  shutdown_select_pin;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  rx, rx2;
    int          fails, tests_run, n;

    adc_power_down_control #(.FULL_CYCLES(40), .EXTCOMP_CYCLES(60)) u_dut (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .sclk, .cs_n, .din, .shutdown_select_pin, .dout,
        .dout_oe, .conversion_strobe, .conversion_strobe_oe,
        .analog_power_on, .bandgap_on);
    serial_host_model host (.pclk, .sclk, .cs_n, .din, .dout);

    // =========================================================
    // shared tasks
    task automatic check(input string w, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", w, e, g);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic state_is(input adc_pd_pkg::pd_state_e s);
        apb(1'b0, adc_pd_pkg::OFS_STATUS, 32'h0);
        check("state", 32'(s), 32'(rd[2:0]));
    endtask : state_is
    task automatic strobe_to(input logic lvl);
        n = 0;
        while (conversion_strobe !== lvl && n < 4000) begin
            @(posedge pclk);
            n++;
        end
    endtask : strobe_to
    task automatic wait_ready();
        n = 0;
        do begin
            apb(1'b0, adc_pd_pkg::OFS_STATUS, 32'h0);
            n += 3;
        end while (rd[2:0] !== 3'h1 && n < 3000);
    endtask : wait_ready
    task automatic read_out(input logic [31:0] e);
        host.xfer(8'h00, rx);
        host.xfer(8'h00, rx2);
        check("result", e, 32'({rx, rx2}));
    endtask : read_out

    // =========================================================
    // scenarios
    task automatic t_por();
        check("strobe", 32'h1, 32'(conversion_strobe));
        check("power", 32'h1, 32'(analog_power_on));
        repeat (520) @(posedge pclk);
        state_is(adc_pd_pkg::ST_READY);
        apb(1'b0, 12'h010, 32'h0);
        check("pslverr", 32'h1, 32'(err));
        host.select(1'b1);
        read_out(32'h0);
    endtask : t_por
    task automatic t_ext();
        apb(1'b1, adc_pd_pkg::OFS_SAMPLE, 32'h0000_0a5c);
        host.xfer(8'h00, rx);
        host.xfer(8'h83, rx);
        read_out(32'h0000_52e0);
        apb(1'b0, adc_pd_pkg::OFS_STATUS, 32'h0);
        check("ext mode", 32'h9, 32'(rd[3:0]));
    endtask : t_ext
    task automatic t_int();
        int dv;
        for (int k = 0; k < 2; k++) begin
            dv = k ? adc_pd_pkg::DIV_FLOAT : adc_pd_pkg::DIV_HIGH;
            shutdown_select_pin <= k ? adc_pd_pkg::PIN_FLOAT
                                     : adc_pd_pkg::PIN_HIGH;
            repeat (4) @(posedge pclk);
            host.xfer(8'h82, rx);
            strobe_to(1'b0);
            check("fall", 32'h1, 32'(n < 20));
            strobe_to(1'b1);
            check("ticks", 32'h1,
                  32'(n >= 12 * dv && n <= 13 * dv + 8));
            read_out(32'h0000_52e0);
        end
    endtask : t_int
    task automatic t_soft();
        shutdown_select_pin <= adc_pd_pkg::PIN_HIGH;
        apb(1'b1, adc_pd_pkg::OFS_SAMPLE, 32'h0000_0333);
        host.xfer(8'h81, rx);
        strobe_to(1'b0);
        strobe_to(1'b1);
        check("last mode", 32'h1, 32'(n >= 12 * adc_pd_pkg::DIV_HIGH));
        repeat (4) @(posedge pclk);
        check("fast off", 32'h0, 32'(analog_power_on));
        check("fast gap", 32'h1, 32'(bandgap_on));
        read_out(32'h0000_1998);
        host.xfer(8'h82, rx);
        check("wake", 32'h1, 32'(analog_power_on));
        state_is(adc_pd_pkg::ST_WAKE);
        wait_ready();
        check("fast wake", 32'h1,
              32'(n < adc_pd_pkg::FAST_CYCLES && n > 100));
        check("released", 32'h1, 32'(conversion_strobe));
        host.xfer(8'h80, rx);
        strobe_to(1'b0);
        strobe_to(1'b1);
        repeat (4) @(posedge pclk);
        check("full off", 32'h0, 32'({analog_power_on, bandgap_on}));
        host.xfer(8'h83, rx);
        repeat (8) @(posedge pclk);
        state_is(adc_pd_pkg::ST_CONV);
    endtask : t_soft
    task automatic t_hw();
        shutdown_select_pin <= adc_pd_pkg::PIN_LOW;
        repeat (5) @(posedge pclk);
        state_is(adc_pd_pkg::ST_HWPD);
        check("hw oe", 32'h0, 32'({dout_oe, conversion_strobe_oe}));
        apb(1'b1, adc_pd_pkg::OFS_CONFIG, 32'h1);
        shutdown_select_pin <= adc_pd_pkg::PIN_HIGH;
        wait_ready();
        check("ref wake", 32'h1, 32'(n >= adc_pd_pkg::REFOFF_CYCLES
            && n <= adc_pd_pkg::REFOFF_CYCLES + 12));
        host.select(1'b0);
    endtask : t_hw

    // =========================================================
    // run control
    task automatic stop_test();
        if (fails == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        shutdown_select_pin = adc_pd_pkg::PIN_HIGH;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_por();
        t_ext();
        t_int();
        t_soft();
        t_hw();
        stop_test();
    end
    initial begin
        repeat (60000) @(posedge pclk);
        fails++;
        stop_test();
    end
endmodule : adc_power_down_control_tb
